// ===== common/cgv_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef CGV_DEFINES_VH
`define CGV_DEFINES_VH
`define CGV_ADDR_RIGHT_PGA 8'h08
`define CGV_ADDR_ADC_INPUT 8'h09
`define CGV_ADDR_LEFT_ATTEN 8'h0a
`define CGV_ADDR_RIGHT_ATTEN 8'h0b
`define CGV_ADDR_DAC_CTRL2 8'h0c
`define CGV_ADDR_IRQ_FLAGS 8'h0d
`define CGV_ADDR_IRQ_MASK 8'h0e
`define CGV_ADDR_IRQ_MODE_MSB 8'h0f
`define CGV_ADDR_IRQ_MODE_LSB 8'h10
`define CGV_ADDR_LEFT_PGA 8'h07
`define CGV_PGA_ZC_BIT 3
`define CGV_PGA_RAMP_BIT 4
`define CGV_POLFLIP_BIT 5
`define CGV_DAC_ZC_BIT 6
`define CGV_DAC_RAMP_BIT 7
`define CGV_IRQPOL_BIT 0
`define CGV_PGA_MASK 8'h3f
`define CGV_ADC_INPUT_MASK 8'h1f
`define CGV_DAC_CTRL2_MASK 8'he1
`define CGV_IRQ_MASK4 8'h0f
`define CGV_ADC_INPUT_RST 5'h18
`define CGV_DAC_CTRL2_RST 8'hc0
`define CGV_IRQ_FLAGS_RST 4'h0
`define CGV_PGA_MIN 6'h28
`define CGV_PGA_MAX 6'h18
`define CGV_STEPS_PER_DB 4'h8
`define CGV_LR_PER_DB 4'h8
`define CGV_ZC_TIMEOUT 11'h200
`define CGV_RAMP_MAX_ATTEN 11'h3fc
`endif

// ===== design/cgv_level_sched.v
// one channel level scheduler: immediate, zero-cross, ramp, ramp+zc
`timescale 1ns/1ps
`default_nettype none
`include "cgv_defines.vh"
module cgv_level_sched
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_lr_tick,
  input wire i_zero_cross,
  input wire i_ramp_en,
  input wire i_zc_en,
  input wire signed [10:0] i_target,
  output reg signed [10:0] o_level,
  output reg o_settled
);
  // level in 1/8 dB units; sample counters are in lr periods
  reg [10:0] zc_timer;
  wire differs = (o_level != i_target);
  // a crossing can land on any clock, so it applies at once; the timeout
  // counts lr periods and so only expires on a tick
  wire zc_ok = i_zero_cross || (i_lr_tick && (zc_timer >= `CGV_ZC_TIMEOUT));
  wire ramp_due = i_lr_tick;
  wire step_dn = (o_level > i_target);
  // ramp moves 1/8 dB per lr period: 1 dB per 8 periods
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_level <= 11'sh000;
      zc_timer <= 11'h000;
      o_settled <= 1'b1;
    end
    else
    begin
      o_settled <= !differs;
      if (!differs || i_zero_cross)
        zc_timer <= 11'h000;
      else if (i_lr_tick && i_zc_en)
        zc_timer <= zc_timer + 11'h001;
      case ({i_ramp_en, i_zc_en})
        2'b00: o_level <= i_target;
        2'b01:
        begin
          if (differs && zc_ok)
          begin
            o_level <= i_target;
            zc_timer <= 11'h000;
          end
        end
        2'b10:
        begin
          if (differs && ramp_due)
            o_level <= step_dn ? o_level - 11'sh001 : o_level + 11'sh001;
        end
        default:
        begin
          if (differs && zc_ok)
          begin
            o_level <= step_dn ? o_level - 11'sh001 : o_level + 11'sh001;
            zc_timer <= 11'h000;
          end
        end
      endcase
    end
  end
endmodule // cgv_level_sched
`default_nettype wire

// ===== design/cgv_regs.v
// codec gain, volume and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
`include "cgv_defines.vh"
module cgv_regs
(
  input wire i_clk,
  input wire i_rstn,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_lrck,
  input wire i_dac_mute,
  input wire [3:0] i_fault,
  input wire signed [23:0] i_dac_left,
  input wire signed [23:0] i_dac_right,
  input wire signed [23:0] i_adc_left,
  input wire signed [23:0] i_adc_right,
  output reg signed [23:0] o_dac_left,
  output reg signed [23:0] o_dac_right,
  output reg signed [10:0] o_pga_left_level,
  output reg signed [10:0] o_pga_right_level,
  output reg [10:0] o_dac_left_atten,
  output reg [10:0] o_dac_right_atten,
  output reg [2:0] o_input_select,
  output reg o_mic_boost,
  output reg o_irq_out,
  output reg o_irq_oe
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [5:0] left_pga_gain;
  reg [5:0] right_pga_gain;
  reg [4:0] adc_input_control;
  reg [7:0] left_dac_attenuation;
  reg [7:0] right_dac_attenuation;
  reg [7:0] dac_control_two;
  reg [3:0] irq_event_flags;
  reg [3:0] irq_mask;
  reg [3:0] irq_mode_msb;
  reg [3:0] irq_mode_lsb;
  reg [3:0] fault_prev;
  reg lr_prev;
  reg [1:0] sign_l_prev;
  reg [1:0] sign_r_prev;
  wire [3:0] fault_s;
  wire lr_s;
  wire mute_s;

  // pin inputs cross into the clock domain first
  cgv_sync2 #(.W(6)) u_sync
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async({i_fault, i_lrck, i_dac_mute}),
    .o_sync({fault_s, lr_s, mute_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // pga code to 1/8 dB units, sign extended
  function signed [10:0] pga_to_eighths;
    input [5:0] code;
    begin
      pga_to_eighths = {{3{code[5]}}, code, 2'b00};
    end
  endfunction

  // attenuation code to 1/8 dB; negative level, mute goes to floor
  function signed [10:0] atten_to_eighths;
    input [7:0] code;
    input mute;
    begin
      if (mute)
        atten_to_eighths = -$signed(`CGV_RAMP_MAX_ATTEN);
      else
        atten_to_eighths = -$signed({1'b0, code, 2'b00});
    end
  endfunction

  wire lr_tick = lr_s && !lr_prev; // one sample period per rising lrck
  wire zc_l = i_adc_left[23] != sign_l_prev[0];
  wire zc_r = i_adc_right[23] != sign_r_prev[0];
  wire dzc_l = i_dac_left[23] != sign_l_prev[1];
  wire dzc_r = i_dac_right[23] != sign_r_prev[1];
  wire pga_ramp = adc_input_control[`CGV_PGA_RAMP_BIT];
  wire pga_zc = adc_input_control[`CGV_PGA_ZC_BIT];
  wire dac_ramp = dac_control_two[`CGV_DAC_RAMP_BIT];
  wire dac_zc = dac_control_two[`CGV_DAC_ZC_BIT];
  wire irq_pol = dac_control_two[`CGV_IRQPOL_BIT];
  wire signed [10:0] lvl_pl;
  wire signed [10:0] lvl_pr;
  wire signed [10:0] lvl_dl;
  wire signed [10:0] lvl_dr;

  ////////////////////////////////////////////////////////////////////////
  // per-channel schedulers, each with its own zero detector and timeout
  cgv_level_sched u_pga_l
  (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_lr_tick(lr_tick),
    .i_zero_cross(zc_l), .i_ramp_en(pga_ramp), .i_zc_en(pga_zc),
    .i_target(pga_to_eighths(left_pga_gain)),
    .o_level(lvl_pl), .o_settled()
  );
  cgv_level_sched u_pga_r
  (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_lr_tick(lr_tick),
    .i_zero_cross(zc_r), .i_ramp_en(pga_ramp), .i_zc_en(pga_zc),
    .i_target(pga_to_eighths(right_pga_gain)),
    .o_level(lvl_pr), .o_settled()
  );
  cgv_level_sched u_dac_l
  (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_lr_tick(lr_tick),
    .i_zero_cross(dzc_l), .i_ramp_en(dac_ramp), .i_zc_en(dac_zc),
    .i_target(atten_to_eighths(left_dac_attenuation, mute_s)),
    .o_level(lvl_dl), .o_settled()
  );
  cgv_level_sched u_dac_r
  (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_lr_tick(lr_tick),
    .i_zero_cross(dzc_r), .i_ramp_en(dac_ramp), .i_zc_en(dac_zc),
    .i_target(atten_to_eighths(right_dac_attenuation, mute_s)),
    .o_level(lvl_dr), .o_settled()
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupt source events per mode; masked sources never reach status
  reg [3:0] src_event;
  integer k;
  always @*
  begin
    src_event = 4'h0;
    for (k = 0; k < 4; k = k + 1)
    begin
      case ({irq_mode_msb[k], irq_mode_lsb[k]})
        2'b00: src_event[k] = fault_s[k] && !fault_prev[k];
        2'b01: src_event[k] = !fault_s[k] && fault_prev[k];
        2'b10: src_event[k] = fault_s[k];
        default: src_event[k] = 1'b0; // reserved mode raises nothing
      endcase
    end
    src_event = src_event & irq_mask;
  end

  wire rd_flags = i_rd && (i_addr == `CGV_ADDR_IRQ_FLAGS);

  ////////////////////////////////////////////////////////////////////////
  // register writes, status capture and datapath outputs
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      left_pga_gain <= 6'h00;
      right_pga_gain <= 6'h00;
      adc_input_control <= `CGV_ADC_INPUT_RST;
      left_dac_attenuation <= 8'h00;
      right_dac_attenuation <= 8'h00;
      dac_control_two <= `CGV_DAC_CTRL2_RST;
      irq_event_flags <= `CGV_IRQ_FLAGS_RST;
      irq_mask <= 4'h0;
      irq_mode_msb <= 4'h0;
      irq_mode_lsb <= 4'h0;
      fault_prev <= 4'h0;
      lr_prev <= 1'b0;
      sign_l_prev <= 2'b00;
      sign_r_prev <= 2'b00;
      o_dac_left <= 24'sh000000;
      o_dac_right <= 24'sh000000;
    end
    else
    begin
      fault_prev <= fault_s;
      lr_prev <= lr_s;
      sign_l_prev <= {i_dac_left[23], i_adc_left[23]};
      sign_r_prev <= {i_dac_right[23], i_adc_right[23]};
      if (i_wr)
      begin
        // reserved bits are dropped on write
        case (i_addr)
          `CGV_ADDR_LEFT_PGA: left_pga_gain <= i_wdata[5:0];
          `CGV_ADDR_RIGHT_PGA: right_pga_gain <= i_wdata[5:0];
          `CGV_ADDR_ADC_INPUT: adc_input_control <= i_wdata[4:0];
          `CGV_ADDR_LEFT_ATTEN: left_dac_attenuation <= i_wdata;
          `CGV_ADDR_RIGHT_ATTEN: right_dac_attenuation <= i_wdata;
          `CGV_ADDR_DAC_CTRL2:
            dac_control_two <= i_wdata & `CGV_DAC_CTRL2_MASK;
          `CGV_ADDR_IRQ_MASK: irq_mask <= i_wdata[3:0];
          `CGV_ADDR_IRQ_MODE_MSB: irq_mode_msb <= i_wdata[3:0];
          `CGV_ADDR_IRQ_MODE_LSB: irq_mode_lsb <= i_wdata[3:0];
          default: ;
        endcase
      end
      // set beats the clear-on-read; masked bits are forced low
      irq_event_flags <= ((rd_flags ? 4'h0 : irq_event_flags) | src_event)
        & irq_mask;
      if (dac_control_two[`CGV_POLFLIP_BIT])
      begin
        o_dac_left <= -i_dac_left;
        o_dac_right <= -i_dac_right;
      end
      else
      begin
        o_dac_left <= i_dac_left;
        o_dac_right <= i_dac_right;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data is registered; it captures flags before the clear lands
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `CGV_ADDR_LEFT_PGA: o_rdata <= {2'b00, left_pga_gain};
        `CGV_ADDR_RIGHT_PGA: o_rdata <= {2'b00, right_pga_gain};
        `CGV_ADDR_ADC_INPUT: o_rdata <= {3'b000, adc_input_control};
        `CGV_ADDR_LEFT_ATTEN: o_rdata <= left_dac_attenuation;
        `CGV_ADDR_RIGHT_ATTEN: o_rdata <= right_dac_attenuation;
        `CGV_ADDR_DAC_CTRL2: o_rdata <= dac_control_two;
        `CGV_ADDR_IRQ_FLAGS:
          o_rdata <= {4'h0, irq_event_flags & irq_mask};
        `CGV_ADDR_IRQ_MASK: o_rdata <= {4'h0, irq_mask};
        `CGV_ADDR_IRQ_MODE_MSB: o_rdata <= {4'h0, irq_mode_msb};
        `CGV_ADDR_IRQ_MODE_LSB: o_rdata <= {4'h0, irq_mode_lsb};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level outputs, input select and irq pin
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_pga_left_level <= 11'sh000;
      o_pga_right_level <= 11'sh000;
      o_dac_left_atten <= 11'h000;
      o_dac_right_atten <= 11'h000;
      o_input_select <= 3'h0;
      o_mic_boost <= 1'b0;
      o_irq_out <= 1'b0;
      o_irq_oe <= 1'b0;
    end
    else
    begin
      o_pga_left_level <= lvl_pl;
      o_pga_right_level <= lvl_pr;
      o_dac_left_atten <= -lvl_dl;
      o_dac_right_atten <= -lvl_dr;
      o_input_select <= adc_input_control[2:0];
      o_mic_boost <= (adc_input_control[2:0] == 3'h0);
      if (irq_pol)
      begin
        o_irq_out <= |irq_event_flags;
        o_irq_oe <= 1'b1;
      end
      else
      begin
        o_irq_out <= 1'b0;
        o_irq_oe <= |irq_event_flags;
      end
    end
  end
endmodule // cgv_regs
`default_nettype wire

// ===== design/cgv_sync2.v
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
`default_nettype none
module cgv_sync2 #(parameter W = 1)
(
  input wire i_clk,
  input wire i_rstn,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta;
  // first stage is read only by the second
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // cgv_sync2
`default_nettype wire

// ===== testbench/cgv_host.sv
// host model driving the control port
`timescale 1ns/1ps
`default_nettype none
module cgv_host
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write strobe, launched just after an edge
  task wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge i_clk);
    #1;
    // gain codes past plus or minus 12 dB are reserved: set them all to the +12 dB code 6'h18
    if ((a == 8'h07 || a == 8'h08) && d[5:0] > 6'h18 && d[5:0] < 6'h28)
      d[5:0] = 6'h18;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1 o_wr = 1'b0;
  end
  endtask
  // read data is taken one edge after the strobe and then holds
  task rd(input logic [7:0] a, output logic [7:0] q);
  begin
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1 o_rd = 1'b0;
    q = i_rdata;
  end
  endtask
endmodule // cgv_host
`default_nettype wire

// ===== testbench/cgv_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module cgv_properties
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic signed [23:0] i_dac_left,
  input wire logic signed [23:0] o_dac_left,
  input wire logic signed [10:0] o_pga_right_level,
  input wire logic [2:0] o_input_select,
  input wire logic o_mic_boost,
  input wire logic o_irq_out,
  input wire logic o_irq_oe
);
  logic [7:0] ctrl2;
  logic [7:0] ain;
  logic [3:0] mask;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  // shadow control bytes, rebuilt from observed writes only
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      ctrl2 <= 8'hc0;
      ain <= 8'h18;
      mask <= 4'h0;
    end
    else if (i_wr)
    begin
      if (i_addr == 8'h0c) ctrl2 <= i_wdata & 8'he1;
      if (i_addr == 8'h09) ain <= i_wdata & 8'h1f;
      if (i_addr == 8'h0e) mask <= i_wdata[3:0];
    end
  ////////////////////////////////////////////////////////////////////////////
  // a read returns the byte as it stood before that edge
  a_ctrl2_readback:
  assert property (i_rd && i_addr == 8'h0c |=> o_rdata == $past(ctrl2))
  else $error("dac control readback differs");
  a_input_readback:
  assert property (i_rd && i_addr == 8'h09 |=> o_rdata == $past(ain))
  else $error("input control readback differs");
  a_flags_upper:
  assert property (i_rd && i_addr == 8'h0d |=> o_rdata[7:4] == 4'h0)
  else $error("status upper bits not zero");
  // mask may have just moved, so allow either of the last two values
  a_masked_zero:
  assert property (i_rd && i_addr == 8'h0d |=>
    (o_rdata[3:0] & ~($past(mask) | $past(mask, 2))) == 4'h0)
  else $error("masked status bit reads one");
  a_select_write:
  assert property (i_wr && i_addr == 8'h09 |-> ##[1:2]
    o_input_select == ain[2:0])
  else $error("input select not updated");
  a_boost_follows:
  assert property ($past(i_rstn, 2) |->
    o_mic_boost == (o_input_select == 3'h0))
  else $error("mic boost does not follow select");
  a_flip_apply:
  assert property ($past(i_rstn) && $stable(ctrl2[5]) |-> o_dac_left ==
    ($past(ctrl2[5]) ? -$past(i_dac_left) : $past(i_dac_left)))
  else $error("dac sample polarity wrong");
  a_pushpull_oe:
  assert property ($past(i_rstn) && ctrl2[0] && $past(ctrl2[0]) |-> o_irq_oe)
  else $error("push-pull pin not driven");
  a_drain_low:
  assert property (!ctrl2[0] && !$past(ctrl2[0]) |-> !o_irq_out)
  else $error("open drain pin driven high");
  // ramping moves the level one eighth dB at a time, never a jump
  a_ramp_step:
  assert property ($past(i_rstn) && ain[4] && $past(ain[4])
    && $past(ain[4], 2) && $changed(o_pga_right_level) |->
    $past(o_pga_right_level) - o_pga_right_level inside {11'sd1, -11'sd1})
  else $error("ramp step is not one eighth dB");
endmodule // cgv_properties
bind cgv_regs cgv_properties chk_i (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_dac_left(i_dac_left), .o_dac_left(o_dac_left),
  .o_pga_right_level(o_pga_right_level), .o_input_select(o_input_select),
  .o_mic_boost(o_mic_boost), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe));
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the codec register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_lrck = 1'b0;
  logic [3:0] i_fault = 4'h0;
  logic signed [23:0] i_dac_left = 24'h000000;
  logic signed [23:0] i_adc_right = 24'sh000000;
  logic i_dac_mute = 1'b0;
  logic [7:0] i_addr, i_wdata, o_rdata, q;
  logic i_wr, i_rd, o_mic_boost, o_irq_out, o_irq_oe;
  logic signed [23:0] o_dac_left, o_dac_right;
  logic signed [10:0] o_pga_right_level;
  logic signed [10:0] o_pga_left_level;
  logic [10:0] o_dac_left_atten, o_dac_right_atten;
  logic [2:0] o_input_select;
  int mismatches = 0;
  int samples_checked = 0;
  // rows: address, byte written, byte read back
  logic [7:0] rows [0:6][0:2] = '{'{8'h08, 8'hff, 8'h3f},
    '{8'h09, 8'hff, 8'h1f}, '{8'h0a, 8'hff, 8'hff}, '{8'h0b, 8'h29, 8'h29},
    '{8'h0c, 8'hff, 8'he1}, '{8'h11, 8'h5a, 8'h00}, '{8'h0e, 8'hff, 8'h0f}};
  always #5 i_clk = ~i_clk;
  // sample clock of 20 system cycles, its edges on system clock falling edges
  always #100 i_lrck = ~i_lrck;
  cgv_host host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  cgv_regs uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_lrck(i_lrck), .i_dac_mute(i_dac_mute), .i_fault(i_fault),
    .i_dac_left(i_dac_left), .i_dac_right(i_dac_left),
    .i_adc_left(24'sh000000), .i_adc_right(i_adc_right),
    .o_dac_left(o_dac_left), .o_dac_right(o_dac_right),
    .o_pga_left_level(o_pga_left_level),
    .o_pga_right_level(o_pga_right_level), .o_dac_left_atten(o_dac_left_atten),
    .o_dac_right_atten(o_dac_right_atten), .o_input_select(o_input_select),
    .o_mic_boost(o_mic_boost), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // fault pulse long enough to pass the input synchroniser
  task fault(input logic [3:0] f);
  begin
    i_fault = f;
    repeat (6) @(posedge i_clk);
    #1 i_fault = 4'h0;
    repeat (6) @(posedge i_clk);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    repeat (3) @(posedge i_clk);
    host.rd(8'h09, q); chk(q, 8'h18);
    host.rd(8'h0c, q); chk(q, 8'hc0);
    host.rd(8'h0d, q); chk(q, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 7; i++)
    begin
      host.wr(rows[i][0], rows[i][1]);
      host.rd(rows[i][0], q);
      chk(q, rows[i][2]);
    end
    $display("test register rows done");
    host.wr(8'h09, 8'h00);
    repeat (2) @(posedge i_clk);
    #1 chk(o_mic_boost, 1'b1);
    // sticky flag on an open drain pin, cleared by the read
    host.wr(8'h0c, 8'h00);
    fault(4'h8);
    #1 chk({o_irq_oe, o_irq_out}, 2'b10);
    host.rd(8'h0d, q); chk(q, 8'h08);
    host.rd(8'h0d, q); chk(q, 8'h00);
    // only the unmasked source reaches the flags and the push-pull pin
    host.wr(8'h0e, 8'h01);
    fault(4'h7);
    host.wr(8'h0c, 8'h01);
    repeat (3) @(posedge i_clk);
    #1 chk({o_irq_oe, o_irq_out}, 2'b11);
    host.rd(8'h0d, q); chk(q, 8'h01);
    // falling mode flags the removal, level mode flags while it lasts
    host.wr(8'h10, 8'h01);
    i_fault = 4'h1;
    repeat (6) @(posedge i_clk);
    host.rd(8'h0d, q); chk(q, 8'h00);
    i_fault = 4'h0;
    repeat (6) @(posedge i_clk);
    host.rd(8'h0d, q); chk(q, 8'h01);
    host.wr(8'h0f, 8'h01);
    host.wr(8'h10, 8'h00);
    i_fault = 4'h1;
    repeat (6) @(posedge i_clk);
    host.rd(8'h0d, q); chk(q, 8'h01);
    host.rd(8'h0d, q); chk(q, 8'h01);
    i_fault = 4'h0;
    repeat (6) @(posedge i_clk);
    host.rd(8'h0d, q); chk(q, 8'h01);
    host.rd(8'h0d, q); chk(q, 8'h00);
    $display("test status flags done");
    host.wr(8'h0c, 8'h20);
    i_dac_left = 24'sh000123;
    repeat (3) @(posedge i_clk);
    #1 chk($unsigned(o_dac_left), 24'hfffedd);
    chk($unsigned(o_dac_right), 24'hfffedd);
    host.wr(8'h0a, 8'h29);
    repeat (60) @(posedge i_clk);
    #1 chk(o_dac_left_atten, 11'h0a4);
    // ramp: eight steps take eight sample periods, not one
    host.wr(8'h0c, 8'h80);
    host.wr(8'h0b, 8'h2b);
    repeat (40) @(posedge i_clk);
    chk(o_dac_right_atten == 11'h0ac, 1'b0);
    chk($unsigned(o_dac_left), 24'h000123);
    repeat (300) @(posedge i_clk);
    #1 chk(o_dac_right_atten, 11'h0ac);
    // mute drives the level to the floor through the same scheduling
    host.wr(8'h0c, 8'h00);
    i_dac_mute = 1'b1;
    repeat (10) @(posedge i_clk);
    #1 chk(o_dac_left_atten, 11'h3fc);
    i_dac_mute = 1'b0;
    repeat (10) @(posedge i_clk);
    #1 chk(o_dac_left_atten, 11'h0a4);
    host.wr(8'h09, 8'h01);
    host.wr(8'h08, 8'h28);
    repeat (60) @(posedge i_clk);
    #1 chk($unsigned(o_pga_right_level), 11'h7a0);
    chk({o_input_select, o_mic_boost}, 4'h2);
    host.wr(8'h09, 8'h10);
    host.wr(8'h08, 8'h18);
    repeat (100) @(posedge i_clk);
    chk(o_pga_right_level == 11'sh060, 1'b0);
    // 192 eighth-dB steps at one per 20-cycle sample period
    repeat (3800) @(posedge i_clk);
    #1 chk($unsigned(o_pga_right_level), 11'h060);
    // zero-cross only: right moves at its crossing, left waits for timeout
    host.wr(8'h09, 8'h08);
    host.wr(8'h07, 8'h10);
    host.wr(8'h08, 8'h00);
    repeat (100) @(posedge i_clk);
    #1 chk($unsigned(o_pga_right_level), 11'h060);
    i_adc_right = -24'sd1;
    repeat (4) @(posedge i_clk);
    #1 chk($unsigned(o_pga_right_level), 11'h000);
    chk($unsigned(o_pga_left_level), 11'h000);
    repeat (9000) @(posedge i_clk);
    #1 chk($unsigned(o_pga_left_level), 11'h000);
    repeat (1500) @(posedge i_clk);
    #1 chk($unsigned(o_pga_left_level), 11'h040);
    // ramp plus zero-cross: each crossing buys exactly one eighth dB step
    host.wr(8'h09, 8'h18);
    host.wr(8'h08, 8'h01);
    repeat (4) @(posedge i_clk);
    #1 i_adc_right = 24'sh000000;
    repeat (4) @(posedge i_clk);
    #1 i_adc_right = -24'sd1;
    repeat (4) @(posedge i_clk);
    #1 chk($unsigned(o_pga_right_level), 11'h002);
    $display("test levels done");
    end_sim;
  end
  // watchdog sized well above the fifteen thousand cycles the tests need
  initial
  begin
    #400000;
    mismatches++;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
